// >>> pwr_pkg.sv
package pwr_pkg;

  localparam logic [7:0] ADDR_CONTROL = 8'h00;
  localparam logic [7:0] ADDR_UNLOCK  = 8'h04;
  localparam logic [7:0] ADDR_STATUS  = 8'h08;
  localparam logic [7:0] ADDR_MASK    = 8'h0C;

  localparam int BIT_HXT_EN   = 0;
  localparam int BIT_LXT_EN   = 1;
  localparam int BIT_HRC_EN   = 2;
  localparam int BIT_LRC_EN   = 3;
  localparam int BIT_WU_DLY   = 4;
  localparam int BIT_WU_IE    = 5;
  localparam int BIT_WU_FLAG  = 6;
  localparam int BIT_PD_EN    = 7;
  localparam int BIT_WAIT_CPU = 8;

  localparam logic [8:0] CONTROL_RESET = 9'h01F;
  localparam logic [8:0] WRITE_MASK    = 9'h1BF;

  localparam logic [7:0] UNLOCK_KEY0 = 8'h59;
  localparam logic [7:0] UNLOCK_KEY1 = 8'h16;
  localparam logic [7:0] UNLOCK_KEY2 = 8'h88;

  localparam int WAKE_DELAY_CRYSTAL = 4096;
  localparam int WAKE_DELAY_RC      = 256;

  localparam int EVENT_BITS = 3;

  typedef enum logic [1:0]
  {
    ST_RUN      = 2'b00,
    ST_IDLE     = 2'b01,
    ST_DOWN     = 2'b10,
    ST_SETTLE   = 2'b11
  } power_state_t;

  typedef struct packed
  {
    logic hxtOn;
    logic hrcOn;
    logic lxtOn;
    logic lrcOn;
    logic pllOn;
    logic sysClkOn;
    logic cpuClkOn;
    logic fastPeriphOn;
  } clock_gates_t;

endpackage

// >>> unlock_seq.sv
`timescale 1ns/1ps
// Watches byte writes to the unlock register and opens protection after the key sequence.
module unlock_seq
(
  input  wire logic       clk,
  input  wire logic       nrst,
  input  wire logic       wrStrobe,
  input  wire logic [7:0] wrByte,
  output logic            unlocked
);

  logic [1:0] step_q;
  logic       unlocked_q;

  assign unlocked = unlocked_q;

  // Any other byte restarts the sequence and locks protection again.
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      step_q     <= 2'h0;
      unlocked_q <= 1'b0;
    end
    else if (wrStrobe)
    begin
      if (step_q == 2'h0 && wrByte == pwr_pkg::UNLOCK_KEY0)
      begin
        step_q <= 2'h1;
      end
      else if (step_q == 2'h1 && wrByte == pwr_pkg::UNLOCK_KEY1)
      begin
        step_q <= 2'h2;
      end
      else if (step_q == 2'h2 && wrByte == pwr_pkg::UNLOCK_KEY2)
      begin
        step_q     <= 2'h0;
        unlocked_q <= 1'b1;
      end
      else
      begin
        step_q     <= 2'h0;
        unlocked_q <= 1'b0;
      end
    end
  end

endmodule

// >>> power_down_entry_wake_control.sv
// Added by the designer: the Wishbone interface to the registers.
`timescale 1ns/1ps
module power_down_entry_wake_control
#(
  parameter int DELAY_CRYSTAL = pwr_pkg::WAKE_DELAY_CRYSTAL,
  parameter int DELAY_RC      = pwr_pkg::WAKE_DELAY_RC
)
(
  input  wire logic                                clk,
  input  wire logic                                nrst,
  input  wire logic                                wb_cyc_i,
  input  wire logic                                wb_stb_i,
  input  wire logic                                wb_we_i,
  input  wire logic [7:0]                          wb_adr_i,
  input  wire logic [31:0]                         wb_dat_i,
  input  wire logic [3:0]                          wb_sel_i,
  output logic [31:0]                              wb_dat_o,
  output logic                                     wb_ack_o,
  input  wire logic                                cpuSleep,
  input  wire logic                                sysClkFromCrystal,
  input  wire logic                                lowSpeedPeriph,
  input  wire logic [pwr_pkg::EVENT_BITS+3:0]      wakeSources,
  output pwr_pkg::clock_gates_t                    gates,
  output logic                                     powerDown,
  output logic                                     wakeIrq,
  output logic                                     irq
);

  // The wake delay counter is 16 bits wide, so longer or empty delays are refused.
  if (DELAY_CRYSTAL < 1 || DELAY_RC < 1 || DELAY_CRYSTAL > 65535 || DELAY_RC > 65535)
  begin
    $error("wake delay counts out of range");
  end

  localparam int WS = pwr_pkg::EVENT_BITS + 4;

  logic [8:0]              ctrl_q;
  logic [1:0]              stat_q;
  logic [1:0]              mask_q;
  logic [31:0]             rdata_q;
  logic                    ack_q;
  logic                    irq_q;
  logic                    wakeIrq_q;
  logic                    pd_q;
  pwr_pkg::clock_gates_t   gates_q;
  pwr_pkg::power_state_t   state_q;
  logic [15:0]             delay_q;
  logic [WS-1:0]           wsMeta_q;
  logic [WS-1:0]           wsSync_q;
  logic                    slpMeta_q;
  logic                    slpSync_q;
  logic                    wbWrite;
  logic                    unlocked;
  logic                    wakeEvent;
  logic                    wakeEdge;
  logic                    prevDown_q;
  logic                    enterDown;

  assign wb_dat_o = rdata_q;
  assign wb_ack_o = ack_q;
  assign irq      = irq_q;
  assign wakeIrq  = wakeIrq_q;
  assign powerDown = pd_q;
  assign gates    = gates_q;

  assign wbWrite   = wb_cyc_i && wb_stb_i && wb_we_i && !ack_q;
  assign wakeEvent = |wsSync_q;

  // Wake sources and sleep come from other clock domains and are synchronised.
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      wsMeta_q  <= '0;
      wsSync_q  <= '0;
      slpMeta_q <= 1'b0;
      slpSync_q <= 1'b0;
    end
    else
    begin
      wsMeta_q  <= wakeSources;
      wsSync_q  <= wsMeta_q;
      slpMeta_q <= cpuSleep;
      slpSync_q <= slpMeta_q;
    end
  end

  unlock_seq u_unlock
  (
    .clk      (clk),
    .nrst     (nrst),
    .wrStrobe (wbWrite && wb_adr_i == pwr_pkg::ADDR_UNLOCK && wb_sel_i[0]),
    .wrByte   (wb_dat_i[7:0]),
    .unlocked (unlocked)
  );

  // Single-cycle acknowledge; ack drops in the following cycle.
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      ack_q   <= 1'b0;
      rdata_q <= 32'h0000_0000;
    end
    else
    begin
      ack_q <= wb_cyc_i && wb_stb_i && !ack_q;
      unique case (wb_adr_i)
        pwr_pkg::ADDR_CONTROL: rdata_q <= {23'h000000, ctrl_q};
        pwr_pkg::ADDR_UNLOCK:  rdata_q <= {31'h00000000, unlocked};
        pwr_pkg::ADDR_STATUS:  rdata_q <= {30'h00000000, stat_q};
        pwr_pkg::ADDR_MASK:    rdata_q <= {30'h00000000, mask_q};
        default:               rdata_q <= 32'h0000_0000;
      endcase
    end
  end

  assign enterDown = (state_q == pwr_pkg::ST_RUN || state_q == pwr_pkg::ST_IDLE) && ctrl_q[pwr_pkg::BIT_PD_EN]
                     && (!ctrl_q[pwr_pkg::BIT_WAIT_CPU] || slpSync_q);
  assign wakeEdge  = state_q == pwr_pkg::ST_DOWN && wakeEvent;

  // Control register with protection, self-clearing enable and write-one-to-clear flag.
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      ctrl_q <= pwr_pkg::CONTROL_RESET;
    end
    else
    begin
      if (wbWrite && wb_adr_i == pwr_pkg::ADDR_CONTROL && unlocked)
      begin
        for (int i = 0; i < 9; i++)
        begin
          if (pwr_pkg::WRITE_MASK[i] && wb_sel_i[i/8])
          begin
            ctrl_q[i] <= wb_dat_i[i];
          end
        end
      end
      if (wbWrite && wb_adr_i == pwr_pkg::ADDR_CONTROL && wb_sel_i[0] && wb_dat_i[pwr_pkg::BIT_WU_FLAG])
      begin
        ctrl_q[pwr_pkg::BIT_WU_FLAG] <= 1'b0;
      end
      if (wakeEdge)
      begin
        ctrl_q[pwr_pkg::BIT_PD_EN] <= 1'b0;
        if (ctrl_q[pwr_pkg::BIT_WU_IE])
        begin
          ctrl_q[pwr_pkg::BIT_WU_FLAG] <= 1'b1;
        end
      end
    end
  end

  // Power state machine with optional wake delay.
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      state_q <= pwr_pkg::ST_RUN;
      delay_q <= 16'h0000;
    end
    else
    begin
      unique case (state_q)
        pwr_pkg::ST_RUN, pwr_pkg::ST_IDLE:
        begin
          if (enterDown)
          begin
            state_q <= pwr_pkg::ST_DOWN;
          end
          else
          begin
            state_q <= slpSync_q ? pwr_pkg::ST_IDLE : pwr_pkg::ST_RUN;
          end
        end
        pwr_pkg::ST_DOWN:
        begin
          if (wakeEvent)
          begin
            if (ctrl_q[pwr_pkg::BIT_WU_DLY])
            begin
              delay_q <= sysClkFromCrystal ? 16'(DELAY_CRYSTAL - 1) : 16'(DELAY_RC - 1);
              state_q <= pwr_pkg::ST_SETTLE;
            end
            else
            begin
              state_q <= pwr_pkg::ST_RUN;
            end
          end
        end
        pwr_pkg::ST_SETTLE:
        begin
          if (delay_q == 16'h0000)
          begin
            state_q <= pwr_pkg::ST_RUN;
          end
          else
          begin
            delay_q <= delay_q - 16'h0001;
          end
        end
      endcase
    end
  end

  // Clock gate outputs follow the power state, except lxtOn and lrcOn, which follow only their enable bits.
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      gates_q <= '0;
      pd_q    <= 1'b0;
    end
    else
    begin
      pd_q                 <= state_q == pwr_pkg::ST_DOWN;
      gates_q.hxtOn        <= ctrl_q[pwr_pkg::BIT_HXT_EN] && state_q != pwr_pkg::ST_DOWN;
      gates_q.hrcOn        <= ctrl_q[pwr_pkg::BIT_HRC_EN] && state_q != pwr_pkg::ST_DOWN;
      gates_q.lxtOn        <= ctrl_q[pwr_pkg::BIT_LXT_EN];
      gates_q.lrcOn        <= ctrl_q[pwr_pkg::BIT_LRC_EN];
      gates_q.pllOn        <= state_q == pwr_pkg::ST_RUN || state_q == pwr_pkg::ST_IDLE
                              || state_q == pwr_pkg::ST_SETTLE;
      gates_q.sysClkOn     <= state_q == pwr_pkg::ST_RUN || state_q == pwr_pkg::ST_IDLE;
      gates_q.cpuClkOn     <= state_q == pwr_pkg::ST_RUN && !(slpSync_q && !enterDown);
      gates_q.fastPeriphOn <= state_q == pwr_pkg::ST_RUN || state_q == pwr_pkg::ST_IDLE
                              || lowSpeedPeriph;
    end
  end

  // Interrupt status, mask and outputs.
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      stat_q    <= 2'h0;
      mask_q    <= 2'h0;
      irq_q     <= 1'b0;
      wakeIrq_q <= 1'b0;
    end
    else
    begin
      if (wbWrite && wb_adr_i == pwr_pkg::ADDR_MASK && wb_sel_i[0])
      begin
        mask_q <= wb_dat_i[1:0];
      end
      for (int i = 0; i < 2; i++)
      begin
        if (wbWrite && wb_adr_i == pwr_pkg::ADDR_STATUS && wb_sel_i[0] && wb_dat_i[i])
        begin
          stat_q[i] <= 1'b0;
        end
      end
      if (wakeEdge)
      begin
        stat_q[0] <= 1'b1;
      end
      if (enterDown)
      begin
        stat_q[1] <= 1'b1;
      end
      wakeIrq_q <= ctrl_q[pwr_pkg::BIT_WU_FLAG] && ctrl_q[pwr_pkg::BIT_WU_IE];
      irq_q     <= |(stat_q & mask_q);
    end
  end

  // Wait mode armed and the core asleep.
  sequence s_wait_armed;
    (state_q == pwr_pkg::ST_RUN || state_q == pwr_pkg::ST_IDLE) && ctrl_q[pwr_pkg::BIT_PD_EN]
    && ctrl_q[pwr_pkg::BIT_WAIT_CPU] && slpSync_q;
  endsequence

  // Wake event seen in power down with the delay enabled.
  sequence s_wake_delayed;
    state_q == pwr_pkg::ST_DOWN && wakeEvent && ctrl_q[pwr_pkg::BIT_WU_DLY];
  endsequence

  a_wake_clears_en: assert property (@(posedge clk) disable iff (!nrst)
    wakeEdge |=> !ctrl_q[pwr_pkg::BIT_PD_EN])
    else $error("enable not cleared on wake");

  a_down_gates_fast: assert property (@(posedge clk) disable iff (!nrst)
    state_q == pwr_pkg::ST_DOWN |=> !gates_q.hxtOn && !gates_q.hrcOn && !gates_q.sysClkOn)
    else $error("fast clocks on in power down");

  a_nowait_entry: assert property (@(posedge clk) disable iff (!nrst)
    state_q == pwr_pkg::ST_RUN && ctrl_q[pwr_pkg::BIT_PD_EN] && !ctrl_q[pwr_pkg::BIT_WAIT_CPU]
    |=> state_q == pwr_pkg::ST_DOWN)
    else $error("no immediate entry");

  a_wait_holds: assert property (@(posedge clk) disable iff (!nrst)
    state_q == pwr_pkg::ST_RUN && ctrl_q[pwr_pkg::BIT_WAIT_CPU] && !slpSync_q
    |=> state_q != pwr_pkg::ST_DOWN)
    else $error("entered without sleep");

  a_wait_entry: assert property (@(posedge clk) disable iff (!nrst)
    s_wait_armed |=> state_q == pwr_pkg::ST_DOWN)
    else $error("no entry after sleep");

  a_flag_needs_ie: assert property (@(posedge clk) disable iff (!nrst)
    $rose(ctrl_q[pwr_pkg::BIT_WU_FLAG]) |-> $past(ctrl_q[pwr_pkg::BIT_WU_IE]))
    else $error("flag set while disabled");

  a_flag_on_wake: assert property (@(posedge clk) disable iff (!nrst)
    wakeEdge && ctrl_q[pwr_pkg::BIT_WU_IE] |=> ctrl_q[pwr_pkg::BIT_WU_FLAG])
    else $error("flag not set on wake");

  a_wake_irq: assert property (@(posedge clk) disable iff (!nrst)
    ctrl_q[pwr_pkg::BIT_WU_FLAG] && ctrl_q[pwr_pkg::BIT_WU_IE] |=> wakeIrq_q)
    else $error("wake interrupt missing");

  a_low_follow: assert property (@(posedge clk) disable iff (!nrst)
    1'b1 |=> gates_q.lxtOn == $past(ctrl_q[pwr_pkg::BIT_LXT_EN]))
    else $error("low speed crystal gated");

  a_down_pll: assert property (@(posedge clk) disable iff (!nrst)
    state_q == pwr_pkg::ST_DOWN |=> !gates_q.pllOn)
    else $error("pll running in power down");

  a_idle_cpu_off: assert property (@(posedge clk) disable iff (!nrst)
    state_q == pwr_pkg::ST_IDLE |=> !gates_q.cpuClkOn)
    else $error("cpu clock running in idle");

  a_delay_start: assert property (@(posedge clk) disable iff (!nrst)
    s_wake_delayed |=> state_q == pwr_pkg::ST_SETTLE)
    else $error("wake delay skipped");

  a_settle_sys: assert property (@(posedge clk) disable iff (!nrst)
    state_q == pwr_pkg::ST_SETTLE |=> !gates_q.sysClkOn)
    else $error("system clock on during wake delay");

  a_locked_write: assert property (@(posedge clk) disable iff (!nrst)
    wbWrite && wb_adr_i == pwr_pkg::ADDR_CONTROL && !unlocked && !wakeEdge
    |=> ctrl_q[pwr_pkg::BIT_WAIT_CPU] == $past(ctrl_q[pwr_pkg::BIT_WAIT_CPU]))
    else $error("protected bit changed while locked");

endmodule

// >>> cpu_model.sv
`timescale 1ns/1ps
module cpu_model
(
  input  wire logic       clk,
  input  wire logic       nrst,
  input  wire logic       sleepCmd,
  input  wire logic       wakeCmd,
  input  wire logic [6:0] wakeSel,
  output logic            cpuSleep,
  output logic [6:0]      wakeSources
);
  // The core sleeps on command and leaves sleep on any wake event.
  always_ff @(posedge clk)
  begin
    if (!nrst)
      cpuSleep <= 1'b0;
    else if (wakeCmd)
      cpuSleep <= 1'b0;
    else if (sleepCmd)
      cpuSleep <= 1'b1;
  end
  // Wake sources stay quiet unless an event is raised.
  assign wakeSources = wakeCmd ? wakeSel : 7'h00;
endmodule

// >>> tb_top.sv
`timescale 1ns/1ps
`define CK(nm, e, s) begin nTests++; if ((s) !== (e)) begin mismatches++; \
  $display("CHECK FAILED %s exp %0h got %0h", nm, e, s); end end
module tb_top;
  logic                  clk = 1'b0;
  logic                  nrst = 1'b0;
  logic                  cyc = 1'b0;
  logic                  stb = 1'b0;
  logic                  wen = 1'b0;
  logic [7:0]            adr = 8'h00;
  logic [31:0]           wdat = 32'h0;
  logic [31:0]           rdat;
  logic                  ack;
  logic                  sleepCmd = 1'b0;
  logic                  wakeCmd = 1'b0;
  logic [6:0]            wakeSel = 7'h01;
  logic                  xtal = 1'b0;
  logic                  lsp = 1'b1;
  logic                  cpuSleep;
  logic [6:0]            wakeSources;
  pwr_pkg::clock_gates_t gates;
  logic                  powerDown;
  logic                  wakeIrq;
  logic                  irq;
  logic [8:0]            ctl = pwr_pkg::CONTROL_RESET;
  logic [31:0]           rnd = 32'h84D0;
  logic [31:0]           r;
  int                    ks = 0;
  int                    mismatches = 0;
  int                    nTests = 0;
  localparam int         RC_DELAY = 4;
  always #2.5 clk = ~clk;
  power_down_entry_wake_control #(.DELAY_CRYSTAL(8), .DELAY_RC(RC_DELAY)) DUT
  (
    .clk(clk), .nrst(nrst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(wen),
    .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(4'hF), .wb_dat_o(rdat),
    .wb_ack_o(ack), .cpuSleep(cpuSleep), .sysClkFromCrystal(xtal),
    .lowSpeedPeriph(lsp), .wakeSources(wakeSources), .gates(gates),
    .powerDown(powerDown), .wakeIrq(wakeIrq), .irq(irq)
  );
  cpu_model CPU
  (
    .clk(clk), .nrst(nrst), .sleepCmd(sleepCmd), .wakeCmd(wakeCmd),
    .wakeSel(wakeSel), .cpuSleep(cpuSleep), .wakeSources(wakeSources)
  );
  function automatic logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  task automatic end_sim;
    $display("tests %0d mismatches %0d", nTests, mismatches);
    if (mismatches == 0 && nTests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    int n;
    cyc <= 1'b1;
    stb <= 1'b1;
    wen <= we;
    adr <= a;
    wdat <= d;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (ack !== 1'b1 && n < 50);
    r = rdat;
    if (n >= 50)
      mismatches++;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
    if (we && a == pwr_pkg::ADDR_CONTROL)
    begin
      if (ks == 3)
        ctl = (ctl & ~pwr_pkg::WRITE_MASK) | (d[8:0] & pwr_pkg::WRITE_MASK);
      if (d[6])
        ctl[6] = 1'b0;
    end
    if (we && a == pwr_pkg::ADDR_UNLOCK)
      ks = (ks == 0 && d[7:0] == pwr_pkg::UNLOCK_KEY0) ? 1 : (ks == 1 && d[7:0] == pwr_pkg::UNLOCK_KEY1) ? 2 :
           (ks == 2 && d[7:0] == pwr_pkg::UNLOCK_KEY2) ? 3 : 0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    `CK("read", e, r)
  endtask
  task automatic waitPd(input logic v);
    int n;
    n = 0;
    while (powerDown !== v && n < 40)
    begin
      @(posedge clk);
      n++;
    end
    `CK("powerDown", v, powerDown)
  endtask
  task automatic wake(input logic dly);
    rnd = xs(rnd);
    wakeSel <= rnd[6:0] | 7'h01;
    wakeCmd <= 1'b1;
    repeat (4) @(posedge clk);
    wakeCmd <= 1'b0;
    waitPd(1'b0);
    `CK("settle", !dly, gates.sysClkOn)
    if (dly)
    begin
      repeat (RC_DELAY - 1) @(posedge clk);
      `CK("settleEnd", 1'b0, gates.sysClkOn)
      @(posedge clk);
      `CK("settleOut", 1'b1, gates.sysClkOn)
    end
    repeat (20) @(posedge clk);
    `CK("sysClk", 1'b1, gates.sysClkOn)
    `CK("hxt", 1'b1, gates.hxtOn)
  endtask
  initial
  begin
    #(5.0 * 20000);
    mismatches++;
    end_sim();
  end
  initial
  begin
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    rd(pwr_pkg::ADDR_CONTROL, {23'h0, ctl});
    rd(8'h10, 32'h0);
    rnd = xs(rnd);
    wb(1'b1, pwr_pkg::ADDR_CONTROL, rnd | 32'h80);
    rd(pwr_pkg::ADDR_CONTROL, {23'h0, ctl});
    `CK("pdLocked", 1'b0, powerDown)
    sleepCmd <= 1'b1;
    repeat (10) @(posedge clk);
    `CK("idleCpu", 1'b0, gates.cpuClkOn)
    `CK("idleSys", 1'b1, gates.sysClkOn)
    `CK("idlePd", 1'b0, powerDown)
    sleepCmd <= 1'b0;
    wakeCmd <= 1'b1;
    @(posedge clk);
    wakeCmd <= 1'b0;
    $display("test lock and idle done");
    wb(1'b1, pwr_pkg::ADDR_UNLOCK, 32'h59);
    wb(1'b1, pwr_pkg::ADDR_UNLOCK, 32'h16);
    wb(1'b1, pwr_pkg::ADDR_UNLOCK, 32'h88);
    rd(pwr_pkg::ADDR_UNLOCK, 32'h1);
    xtal <= 1'b1;
    wb(1'b1, pwr_pkg::ADDR_CONTROL, 32'hAF);
    waitPd(1'b1);
    repeat (4) @(posedge clk);
    `CK("gatesDown", 8'h30 | {7'h0, lsp}, gates)
    wake(1'b0);
    ctl[7] = 1'b0;
    ctl[6] = 1'b1;
    rd(pwr_pkg::ADDR_CONTROL, {23'h0, ctl});
    `CK("wakeIrq", 1'b1, wakeIrq)
    rd(pwr_pkg::ADDR_STATUS, 32'h3);
    `CK("irqMasked", 1'b0, irq)
    wb(1'b1, pwr_pkg::ADDR_MASK, 32'h1);
    @(posedge clk);
    `CK("irqOn", 1'b1, irq)
    wb(1'b1, pwr_pkg::ADDR_STATUS, 32'h3);
    @(posedge clk);
    `CK("irqOff", 1'b0, irq)
    wb(1'b1, pwr_pkg::ADDR_CONTROL, 32'h2F);
    rd(pwr_pkg::ADDR_CONTROL, {23'h0, ctl});
    wb(1'b1, pwr_pkg::ADDR_CONTROL, 32'h6F);
    rd(pwr_pkg::ADDR_CONTROL, {23'h0, ctl});
    `CK("wakeIrqOff", 1'b0, wakeIrq)
    $display("test immediate entry done");
    xtal <= 1'b0;
    lsp <= 1'b0;
    wb(1'b1, pwr_pkg::ADDR_CONTROL, 32'h19F);
    repeat (20) @(posedge clk);
    `CK("pdWait", 1'b0, powerDown)
    sleepCmd <= 1'b1;
    @(posedge clk);
    sleepCmd <= 1'b0;
    waitPd(1'b1);
    repeat (4) @(posedge clk);
    `CK("periphOff", 1'b0, gates.fastPeriphOn)
    wake(1'b1);
    ctl[7] = 1'b0;
    rd(pwr_pkg::ADDR_CONTROL, {23'h0, ctl});
    $display("test wait entry done");
    end_sim();
  end
endmodule
